/* src/amp_prot_pkg.sv */
// Constants shared by the amplifier protection and fault monitor.
package amp_prot_pkg;
   localparam int NCH           = 4;  // Amplifier channels.
   localparam int CLK_PERIOD_NS = 25; // mclk period at 40 MHz.
   // Severe-short shutdown window, in microseconds.
   localparam int SHORT_MIN_US  = 200;
   localparam int SHORT_MAX_US  = 390;
   // Least time rounds up, longest time rounds down.
   localparam int SHORT_MIN_CYC =
      (SHORT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_MAX_CYC = (SHORT_MAX_US * 1000) / CLK_PERIOD_NS;
   // Power-stage switching frequency, in kHz.
   localparam int SW_FREQ_KHZ   = 400;
   localparam int SW_PERIOD_CYC =
      1000000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
   // Time base of the offset persistence timer, in microseconds.
   localparam int DC_TICK_US    = 100;
   localparam int DC_TICK_CYC   = (DC_TICK_US * 1000) / CLK_PERIOD_NS;
   // Register offsets.
   localparam logic [7:0] REG_CH_FAULT  = 8'h00;
   localparam logic [7:0] REG_SUPPLY    = 8'h01;
   localparam logic [7:0] REG_LIVE      = 8'h02;
   localparam logic [7:0] REG_TEMP_WARN = 8'h04;
   localparam logic [7:0] REG_GAIN      = 8'h08;
   localparam logic [7:0] REG_COMMAND   = 8'h09;
   localparam logic [7:0] REG_PIN_SEL   = 8'h0A;
   localparam logic [7:0] REG_DC_CTRL   = 8'h0B;
   localparam logic [7:0] REG_PLAY      = 8'h0C;
   localparam logic [7:0] REG_DC_LEVEL  = 8'h0D;
   localparam logic [7:0] REG_DC_TIME   = 8'h0E;
   // Field positions.
   localparam int TW_LSB        = 5;  // Warning levels 1..3 at 5..7.
   localparam int CMD_CLEAR_BIT = 0;  // Fault-clear command bit.
   localparam int DC_SHUT_BIT   = 0;  // Offset shutdown enable bit.
   // Reset values.
   localparam logic [7:0] RST_GAIN     = 8'h00;
   localparam logic [3:0] RST_PLAY     = 4'h0;
   localparam logic [7:0] RST_DC_CTRL  = 8'h00;
   localparam logic [7:0] RST_DC_LEVEL = 8'h80;
   localparam logic [7:0] RST_DC_TIME  = 8'h0A;
   // Sources for the shared clip and warning pin.
   typedef enum logic [1:0] {
      PIN_CLIP, PIN_WARN, PIN_BOTH, PIN_TWEETER
   } pin_sel_e;
   localparam pin_sel_e RST_PIN_SEL = PIN_WARN;
endpackage

/* src/chan_if.sv */
// Signals between the top level and one channel guard.
`timescale 1ns/1ps
interface chan_if;
   logic       avgOver;   // Average current above threshold.
   logic       peakOver;  // Peak current detector firing.
   logic [7:0] dcMag;     // Output offset magnitude.
   logic       normalOp;  // Channel playing, not floated.
   logic [7:0] dcLevel;   // Offset trip level.
   logic [7:0] dcTime;    // Offset persistence, in ticks.
   logic       dcTick;    // Persistence time base enable.
   logic       pulseCut;  // Terminate switching pulse.
   logic       shortTrip; // One-cycle severe-short event.
   logic       dcTrip;    // One-cycle offset event.
   modport guard (input avgOver, peakOver, dcMag, normalOp,
                  dcLevel, dcTime, dcTick,
                  output pulseCut, shortTrip, dcTrip);
   modport top   (output avgOver, peakOver, dcMag, normalOp,
                  dcLevel, dcTime, dcTick,
                  input pulseCut, shortTrip, dcTrip);
endinterface

/* src/sync2.sv */
// Two-flop synchroniser.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta; // First stage, read only by q.

   // Bits are unrelated levels.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* src/channel_guard.sv */
// Per-channel current limit, short timer and offset detector.
`timescale 1ns/1ps
module channel_guard
   import amp_prot_pkg::*;
#(
   parameter int SHORT_TRIP_CYC = SHORT_MIN_CYC
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   chan_if.guard     ch
);
   localparam logic [13:0] TRIP_LAST = 14'(SHORT_TRIP_CYC - 1);

   logic [13:0] shortCnt; // Cycles of continuous peak current.
   logic [7:0]  dcCnt;    // Ticks of continuous offset.

   // Trip once the peak detector has held for the whole window.
   wire logic shortDone = ch.peakOver && (shortCnt == TRIP_LAST);
   wire logic dcAbove   = ch.normalOp && (ch.dcMag >= ch.dcLevel);
   wire logic dcDone    = dcAbove && ch.dcTick &&
                          (dcCnt >= ch.dcTime);

   // A brief peak only limits.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shortCnt     <= 14'h0000;
         ch.shortTrip <= 1'b0;
      end else begin
         ch.shortTrip <= shortDone;
         if (!ch.peakOver || shortDone) begin
            shortCnt <= 14'h0000;
         end else begin
            shortCnt <= shortCnt + 14'h0001;
         end
      end
   end

   // Offset must persist for the programmed tick count.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dcCnt     <= 8'h00;
         ch.dcTrip <= 1'b0;
      end else begin
         ch.dcTrip <= dcDone;
         if (!dcAbove || dcDone) begin
            dcCnt <= 8'h00;
         end else if (ch.dcTick && dcCnt != 8'hFF) begin
            dcCnt <= dcCnt + 8'h01;
         end
      end
   end

   // Either detector ends the pulse; the channel keeps switching.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ch.pulseCut <= 1'b0;
      end else begin
         ch.pulseCut <= ch.avgOver || ch.peakOver;
      end
   end
endmodule

/* src/amp_protection_fault_monitor.sv */
// Protection and fault monitor for a four-channel class-D amplifier.
`timescale 1ns/1ps
module amp_protection_fault_monitor
   import amp_prot_pkg::*;
#(
   parameter int SHORT_TRIP_CYC = SHORT_MIN_CYC
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // Register port behind the serial control interface.
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   // Analog comparator levels, asynchronous to mclk.
   input  wire logic [3:0]  avgCurrentOver,
   input  wire logic [3:0]  peakCurrentOver,
   input  wire logic [3:0]  fullDuty,
   input  wire logic [2:0]  thermalWarning,
   input  wire logic        thermalShutdown,
   input  wire logic        thermalFoldback,
   input  wire logic        supplyLowPowerStage,
   input  wire logic        supplyLowAnalog,
   input  wire logic        supplyLowChargePump,
   input  wire logic        supplyHighPowerStage,
   input  wire logic        powerOnReset,
   // Offset magnitudes from the on-chip monitor, on mclk.
   input  wire logic [31:0] dcOffsetMag,
   // Outputs to the power stage and pins.
   output logic      [3:0]  pulseCurrentLimit,
   output logic      [3:0]  outputFloat,
   output logic      [7:0]  chGain,
   output logic             faultPin_n,
   output logic             clipWarningPin_n,
   output logic             serialRelease
);
   localparam logic [11:0] TICK_LAST = 12'(DC_TICK_CYC - 1);
   localparam logic [7:0]  SW_LAST   = 8'(SW_PERIOD_CYC - 1);

   // Synchronised comparator levels.
   logic [21:0] syncOut;

   // Configuration registers.
   logic [7:0]  gainReg;   // Two gain bits per channel.
   pin_sel_e    pinSel;    // Shared pin source.
   logic [7:0]  dcCtrl;    // Offset shutdown enable.
   logic [3:0]  playReg;   // Channel play (switching) enables.
   logic [7:0]  dcLevel;   // Offset trip level.
   logic [7:0]  dcTime;    // Offset persistence in ticks.

   // Sticky status flags.
   logic [3:0]  ocFlag;    // Severe-short shutdowns.
   logic [3:0]  dcFlag;    // Offset detections.
   logic [5:0]  supFlag;   // Supply, heat and reset events.

   // Time base and tweeter low-time stretcher.
   logic [11:0] tickCnt;
   logic        dcTick;
   logic [7:0]  lowHold;

   // Per-channel results gathered from the guards.
   logic [3:0]  shortTrip;
   logic [3:0]  dcTrip;
   logic [3:0]  cutVec;
   logic [7:0]  next_gain;

   // All comparator inputs pass two flops before use.
   sync2 #(
      .W(22)
   ) u_sync (
      .mclk   (mclk),
      .arst_n (arst_n),
      .d      ({avgCurrentOver, peakCurrentOver, fullDuty,
                thermalWarning, thermalShutdown, thermalFoldback,
                supplyLowPowerStage, supplyLowAnalog,
                supplyLowChargePump, supplyHighPowerStage,
                powerOnReset}),
      .q      (syncOut)
   );

   // Named views of the synchronised vector.
   wire logic [3:0] avgS   = syncOut[21:18];
   wire logic [3:0] peakS  = syncOut[17:14];
   wire logic [3:0] dutyS  = syncOut[13:10];
   wire logic [2:0] warnS  = syncOut[9:7];
   wire logic       hotS   = syncOut[6];
   wire logic       foldS  = syncOut[5];
   wire logic       lowPS  = syncOut[4];
   wire logic       lowAS  = syncOut[3];
   wire logic       lowCS  = syncOut[2];
   wire logic       highPS = syncOut[1];
   wire logic       porS   = syncOut[0];

   // Register decode.
   wire logic wrGain  = regWrEn && (regAddr == REG_GAIN);
   wire logic wrCmd   = regWrEn && (regAddr == REG_COMMAND);
   wire logic wrPin   = regWrEn && (regAddr == REG_PIN_SEL);
   wire logic wrDc    = regWrEn && (regAddr == REG_DC_CTRL);
   wire logic wrPlay  = regWrEn && (regAddr == REG_PLAY);
   wire logic wrLevel = regWrEn && (regAddr == REG_DC_LEVEL);
   wire logic wrTime  = regWrEn && (regAddr == REG_DC_TIME);
   wire logic clearCmd = wrCmd && regWrData[CMD_CLEAR_BIT];
   wire logic dcShutEn = dcCtrl[DC_SHUT_BIT];

   // Device-wide faults float every output with no gain ramp.
   wire logic lowAny = lowPS || lowAS || lowCS;
   wire logic globalFloat =
      hotS || lowAny || highPS || porS;

   // Per-channel stops: shorts always, offsets only when enabled.
   wire logic [3:0] chanStop =
      shortTrip | (dcTrip & {4{dcShutEn}});

   // Software play value, or the current one.
   wire logic [3:0] playSw = wrPlay ? regWrData[3:0] : playReg;

   // Faults win over a same-cycle play write: safety first.
   wire logic [3:0] next_play =
      globalFloat ? 4'h0 : (playSw & ~chanStop);

   // Sticky flags: a new event wins over a clear.
   wire logic [3:0] next_oc =
      (ocFlag & ~{4{clearCmd}}) | shortTrip;
   wire logic [3:0] next_dc =
      (dcFlag & ~{4{clearCmd}}) | dcTrip;
   wire logic [5:0] supSet =
      {porS, hotS, highPS, lowCS, lowAS, lowPS};
   wire logic [5:0] next_sup =
      (supFlag & ~{6{clearCmd}}) | supSet;

   // Fault pin: recorded shorts, supply and heat faults, offsets only when shutdown is enabled, or a live device-wide one.
   wire logic faultAny =
      (|next_oc) || (dcShutEn && (|next_dc)) ||
      (|next_sup[4:0]) || globalFloat;

   // Pin sources: any channel clipping, warning level one.
   wire logic clipAny  = |dutyS;
   wire logic warnOne  = warnS[0];
   wire logic tweetAny = |avgS;
   wire logic tweetLow = tweetAny || (lowHold != 8'h00);

   // Pin source selection.
   wire logic pinAssert =
      (pinSel == PIN_CLIP)  ? clipAny :
      (pinSel == PIN_WARN)  ? warnOne :
      (pinSel == PIN_BOTH)  ? (clipAny || warnOne) :
                              tweetLow;

   // Read multiplexer; unmapped offsets read as zero.
   wire logic [7:0] rdMux =
      (regAddr == REG_CH_FAULT)  ? {dcFlag, ocFlag} :
      (regAddr == REG_SUPPLY)    ? {2'b00, supFlag} :
      (regAddr == REG_LIVE)      ? {dutyS, cutVec} :
      (regAddr == REG_TEMP_WARN) ? {warnS, 5'b00000} :
      (regAddr == REG_GAIN)      ? gainReg :
      (regAddr == REG_PIN_SEL)   ? {6'b000000, pinSel} :
      (regAddr == REG_DC_CTRL)   ? dcCtrl :
      (regAddr == REG_PLAY)      ? {4'h0, playReg} :
      (regAddr == REG_DC_LEVEL)  ? dcLevel :
      (regAddr == REG_DC_TIME)   ? dcTime :
                                   8'h00;

   // One guard per channel, plus its gain foldback.
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         chan_if cif ();
         logic [1:0] gSet;

         assign cif.avgOver  = avgS[gi];
         assign cif.peakOver = peakS[gi];
         assign cif.dcMag    = dcOffsetMag[gi*8 +: 8];
         assign cif.normalOp = playReg[gi] && !globalFloat;
         assign cif.dcLevel  = dcLevel;
         assign cif.dcTime   = dcTime;
         assign cif.dcTick   = dcTick;
         assign shortTrip[gi] = cif.shortTrip;
         assign dcTrip[gi]    = cif.dcTrip;
         assign cutVec[gi]    = cif.pulseCut;

         // Foldback drops one gain step, never below the lowest.
         assign gSet = gainReg[gi*2 +: 2];
         assign next_gain[gi*2 +: 2] =
            (foldS && gSet != 2'h0) ? gSet - 2'h1 : gSet;

         channel_guard #(
            .SHORT_TRIP_CYC(SHORT_TRIP_CYC)
         ) u_guard (
            .mclk   (mclk),
            .arst_n (arst_n),
            .ch     (cif.guard)
         );
      end
   endgenerate

   // Pulse termination straight from the guard flops.
   assign pulseCurrentLimit = cutVec;

   // Offset time base: one enable pulse per tick period.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tickCnt <= 12'h000;
         dcTick  <= 1'b0;
      end else begin
         dcTick <= (tickCnt == TICK_LAST);
         if (tickCnt == TICK_LAST) begin
            tickCnt <= 12'h000;
         end else begin
            tickCnt <= tickCnt + 12'h001;
         end
      end
   end

   // Tweeter stretch: low lasts at least one switching period.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lowHold <= 8'h00;
      end else if (tweetAny) begin
         lowHold <= SW_LAST;
      end else if (lowHold != 8'h00) begin
         lowHold <= lowHold - 8'h01;
      end
   end

   // Configuration registers.
   // A power-on reset loses the settings, as the supply would.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gainReg <= RST_GAIN;
         pinSel  <= RST_PIN_SEL;
         dcCtrl  <= RST_DC_CTRL;
         dcLevel <= RST_DC_LEVEL;
         dcTime  <= RST_DC_TIME;
      end else if (porS) begin
         gainReg <= RST_GAIN;
         pinSel  <= RST_PIN_SEL;
         dcCtrl  <= RST_DC_CTRL;
         dcLevel <= RST_DC_LEVEL;
         dcTime  <= RST_DC_TIME;
      end else begin
         // Writes are honoured in thermal shutdown too.
         if (wrGain) begin
            gainReg <= regWrData;
         end
         if (wrPin) begin
            pinSel <= pin_sel_e'(regWrData[1:0]);
         end
         if (wrDc) begin
            dcCtrl <= regWrData;
         end
         if (wrLevel) begin
            dcLevel <= regWrData;
         end
         if (wrTime) begin
            dcTime <= regWrData;
         end
      end
   end

   // Play enables and sticky status flags.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         playReg <= RST_PLAY;
         ocFlag  <= 4'h0;
         dcFlag  <= 4'h0;
         supFlag <= 6'h00;
      end else begin
         playReg <= next_play;
         ocFlag  <= next_oc;
         dcFlag  <= next_dc;
         supFlag <= next_sup;
      end
   end

   // Power stage controls: float follows the play enables.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         outputFloat <= 4'hF;
         chGain      <= RST_GAIN;
      end else begin
         outputFloat <= ~next_play;
         chGain      <= next_gain;
      end
   end

   // Pins, all registered; faultPin_n and clipWarningPin_n active low, serialRelease active high.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         faultPin_n       <= 1'b1;
         clipWarningPin_n <= 1'b1;
         serialRelease    <= 1'b0;
      end else begin
         faultPin_n       <= !faultAny;
         clipWarningPin_n <= !pinAssert;
         serialRelease    <= porS;
      end
   end

   // Read data register; it holds between reads.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         regRdData <= rdMux;
      end
   end
endmodule

/* sim/amp_prot_properties.sv */
// Port-level checks on the fault monitor.
`timescale 1ns/1ps
module amp_prot_properties
   import amp_prot_pkg::*;
#(
   parameter int SHORT_TRIP_CYC = SHORT_MIN_CYC
) (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        regWrEn,
   input wire logic        regRdEn,
   input wire logic [7:0]  regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic [7:0]  regRdData,
   input wire logic [3:0]  avgCurrentOver,
   input wire logic [3:0]  peakCurrentOver,
   input wire logic [3:0]  fullDuty,
   input wire logic [2:0]  thermalWarning,
   input wire logic        thermalShutdown,
   input wire logic        thermalFoldback,
   input wire logic        supplyLowPowerStage,
   input wire logic        supplyLowAnalog,
   input wire logic        supplyLowChargePump,
   input wire logic        supplyHighPowerStage,
   input wire logic        powerOnReset,
   input wire logic [31:0] dcOffsetMag,
   input wire logic [3:0]  pulseCurrentLimit,
   input wire logic [3:0]  outputFloat,
   input wire logic [7:0]  chGain,
   input wire logic        faultPin_n,
   input wire logic        clipWarningPin_n,
   input wire logic        serialRelease
);
   logic [15:0] peakCnt; // Channel 2 peak cycles.
   logic [7:0]  selAge;  // Cycles since source write.
   logic [7:0]  lowCnt;  // Pin low cycles.
   pin_sel_e    selMir;  // Mirrored pin source.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Mirror of the pin source; counters saturate.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         peakCnt <= '0;
         selAge <= '0;
         lowCnt <= '0;
         selMir <= RST_PIN_SEL;
      end else begin
         peakCnt <= peakCurrentOver[2] ?
                    peakCnt + {15'h0, peakCnt != 16'hFFFF} : 16'h0;
         lowCnt <= clipWarningPin_n ? 8'h0 : lowCnt + {7'h0, lowCnt != 8'hFF};
         if (powerOnReset || (regWrEn && regAddr == REG_PIN_SEL)) begin
            selAge <= '0;
            selMir <= powerOnReset ? RST_PIN_SEL : pin_sel_e'(regWrData[1:0]);
         end else begin
            selAge <= selAge + {7'h0, selAge != 8'hFF};
         end
      end
   end
   a_limit_follow: assert property (
      pulseCurrentLimit == ($past(avgCurrentOver, 3) | $past(peakCurrentOver, 3)))
      else $error("limit mismatch");
   a_no_quiet_stop: assert property (
      |(outputFloat & ~$past(outputFloat)) |-> !faultPin_n || serialRelease
         || $past(regWrEn) || $past(regWrEn, 2))
      else $error("stop without fault");
   a_short_window: assert property (
      peakCnt == 16'(SHORT_TRIP_CYC + 6) |-> outputFloat[2] && !faultPin_n)
      else $error("short not stopped");
   a_clip_report: assert property (
      selAge >= 8'd8 && selMir == PIN_CLIP
         |-> clipWarningPin_n == !$past(|fullDuty, 3))
      else $error("clip pin wrong");
   a_warn_report: assert property (
      selAge >= 8'd8 && selMir == PIN_WARN
         |-> clipWarningPin_n == !$past(thermalWarning[0], 3))
      else $error("warning pin wrong");
   a_tweeter_low: assert property (
      $rose(clipWarningPin_n) && selMir == PIN_TWEETER && selAge > 8'd120
         |-> lowCnt >= 8'(SW_PERIOD_CYC))
      else $error("tweeter low short");
   a_thermal_float: assert property (
      $past(thermalShutdown, 3) |-> outputFloat == 4'hF && !faultPin_n)
      else $error("thermal float missing");
   a_supply_float: assert property (
      $past(supplyLowPowerStage | supplyLowAnalog | supplyLowChargePump
            | supplyHighPowerStage, 3) |-> outputFloat == 4'hF && !faultPin_n)
      else $error("supply float missing");
   a_por_release: assert property (
      $past(powerOnReset, 3) |-> serialRelease)
      else $error("serial port not released");
endmodule
bind amp_protection_fault_monitor amp_prot_properties #(
   .SHORT_TRIP_CYC(SHORT_TRIP_CYC)
) chk (.*);

/* sim/sys_ctl_model.sv */
// Controller model on the register port.
`timescale 1ns/1ps
module sys_ctl_model
   import amp_prot_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] regRdData,
   output logic            regWrEn,
   output logic            regRdEn,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWrData
);
   // Idle bus shows inverted copies, not stale values.
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'hFF;
      regWrData = 8'hFF;
   end
   // One write, taken at the rising edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge mclk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask
   // One read; data taken where it stands.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge mclk);
      regRdEn = 1'b0;
      regAddr = ~a;
      @(negedge mclk);
      d = regRdData;
   endtask
   // Play all channels again.
   task automatic restart();
      wr(REG_PLAY, 8'h0F);
   endtask
   // Rewrite the lost pin source and gain settings.
   task automatic reinit(input logic [7:0] g);
      wr(REG_PIN_SEL, 8'h01);
      wr(REG_GAIN, g);
   endtask
endmodule

/* sim/amp_protection_fault_monitor_tb_top.sv */
// Self-checking bench for the fault monitor.
`timescale 1ns/1ps
module amp_protection_fault_monitor_tb_top
   import amp_prot_pkg::*;
;
   localparam int TRIP = 20; // Short trip kept small for run time.
   logic mclk, arst_n, thermalShutdown, thermalFoldback, powerOnReset;
   logic [3:0] avgCurrentOver, peakCurrentOver, fullDuty, sup;
   logic [2:0] thermalWarning;
   logic [31:0] dcOffsetMag, seed;
   logic regWrEn, regRdEn, faultPin_n, clipWarningPin_n, serialRelease;
   logic [7:0] regAddr, regWrData, regRdData, chGain, g;
   logic [3:0] pulseCurrentLimit, outputFloat;
   int bad_count, check_count, cycleCount;
   logic [7:0] rstAddr [8] = '{REG_PIN_SEL, REG_GAIN, REG_DC_CTRL, REG_PLAY,
                               REG_DC_LEVEL, REG_DC_TIME, REG_COMMAND, 8'h30};
   logic [7:0] rstVal [8] = '{8'h01, RST_GAIN, RST_DC_CTRL, 8'h00,
                              RST_DC_LEVEL, RST_DC_TIME, 8'h00, 8'h00};
   amp_protection_fault_monitor #(.SHORT_TRIP_CYC(TRIP)) uut (
      .mclk(mclk), .arst_n(arst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .avgCurrentOver(avgCurrentOver), .peakCurrentOver(peakCurrentOver),
      .fullDuty(fullDuty), .thermalWarning(thermalWarning),
      .thermalShutdown(thermalShutdown), .thermalFoldback(thermalFoldback),
      .supplyLowPowerStage(sup[0]), .supplyLowAnalog(sup[1]),
      .supplyLowChargePump(sup[2]), .supplyHighPowerStage(sup[3]),
      .powerOnReset(powerOnReset), .dcOffsetMag(dcOffsetMag),
      .pulseCurrentLimit(pulseCurrentLimit), .outputFloat(outputFloat),
      .chGain(chGain), .faultPin_n(faultPin_n),
      .clipWarningPin_n(clipWarningPin_n), .serialRelease(serialRelease));
   sys_ctl_model ctl (.mclk(mclk), .regRdData(regRdData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
   // 40 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Hang guard above the run's length.
   always @(posedge mclk) begin
      cycleCount++;
      if (cycleCount == 40000) begin
         bad_count++;
         stop_test();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Each two-bit gain one step down, floor 0.
   function automatic logic [7:0] fold(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i += 2)
         r[i+:2] = (v[i+:2] == 2'd0) ? 2'd0 : v[i+:2] - 2'd1;
      return r;
   endfunction
   // Expected level of the shared pin for a source choice.
   function automatic logic pin_exp(input logic [1:0] s, input logic [3:0] fd,
                                    input logic tw, input logic [3:0] av);
      case (s)
         2'd0: return !(|fd);
         2'd1: return !tw;
         2'd2: return !((|fd) || tw);
         default: return !(|av);
      endcase
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      ctl.rd(a, d);
      check(d, exp);
   endtask
   // Clear flags, restart.
   task automatic recover();
      wait_cyc(5);
      ctl.wr(REG_COMMAND, 8'h01);
      ctl.restart();
      wait_cyc(4);
      check({faultPin_n, 3'h0, outputFloat}, 8'h80);
   endtask
   task automatic stop_test();
      $display("Checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {avgCurrentOver, peakCurrentOver, fullDuty, sup, thermalWarning} = '0;
      {thermalShutdown, thermalFoldback, powerOnReset} = '0;
      dcOffsetMag = '0;
      seed = 32'hD753A5F6;
      arst_n = 1'b0;
      wait_cyc(16);
      arst_n = 1'b1;
      wait_cyc(2);
      for (int i = 0; i < 8; i++) rd_chk(rstAddr[i], rstVal[i]);
      seed = lfsr(seed);
      g = seed[7:0];
      ctl.wr(REG_GAIN, g);
      thermalFoldback = 1'b1;
      wait_cyc(6);
      check(chGain, fold(g));
      thermalFoldback = 1'b0;
      ctl.restart();
      // Overloads limit, never stop.
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         avgCurrentOver = seed[3:0];
         wait_cyc(5);
         check({outputFloat, pulseCurrentLimit}, {4'h0, seed[3:0]});
      end
      avgCurrentOver = '0;
      peakCurrentOver = 4'h2; // Brief short limits.
      wait_cyc(10);
      peakCurrentOver = '0;
      wait_cyc(5);
      check({faultPin_n, 3'h0, outputFloat}, 8'h80);
      peakCurrentOver = 4'h4; // Held short stops ch 2.
      wait_cyc(10);
      check({4'h0, outputFloat}, 8'h00);
      wait_cyc(30);
      check({faultPin_n, 3'h0, outputFloat}, 8'h04);
      peakCurrentOver = '0;
      rd_chk(REG_CH_FAULT, 8'h04);
      recover();
      rd_chk(REG_CH_FAULT, 8'h00);
      // Offset at trip level, one tick.
      ctl.wr(REG_DC_LEVEL, 8'h40);
      ctl.wr(REG_DC_TIME, 8'h01);
      dcOffsetMag = 32'h40000000;
      wait_cyc(9000);
      rd_chk(REG_CH_FAULT, 8'h80);
      check({faultPin_n, 3'h0, outputFloat}, 8'h80);
      ctl.wr(REG_DC_CTRL, 8'h01);
      wait_cyc(9000);
      check({faultPin_n, 3'h0, outputFloat}, 8'h08);
      dcOffsetMag = '0;
      ctl.wr(REG_DC_CTRL, 8'h00);
      recover();
      // Every pin source, random levels.
      for (int s = 0; s < 4; s++) begin
         ctl.wr(REG_PIN_SEL, 8'(s));
         for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            {avgCurrentOver, fullDuty, thermalWarning} = seed[10:0];
            wait_cyc(110);
            check({7'h0, clipWarningPin_n}, {7'h0, pin_exp(2'(s), fullDuty,
                  thermalWarning[0], avgCurrentOver)});
            rd_chk(REG_TEMP_WARN, {thermalWarning, 5'h0});
         end
      end
      avgCurrentOver = 4'h8;
      wait_cyc(5);
      avgCurrentOver = '0;
      wait_cyc(50);
      check({7'h0, clipWarningPin_n}, 8'h00);
      wait_cyc(100);
      ctl.wr(REG_PIN_SEL, 8'h01);
      thermalWarning = 3'h1;
      thermalShutdown = 1'b1;
      wait_cyc(5);
      check({faultPin_n, 3'h0, outputFloat}, 8'h0F);
      rd_chk(REG_SUPPLY, 8'h10);
      thermalShutdown = 1'b0;
      recover();
      check({7'h0, clipWarningPin_n}, 8'h00);
      thermalWarning = '0;
      // Each supply fault alone.
      for (int i = 0; i < 4; i++) begin
         sup = 4'(1 << i);
         wait_cyc(5);
         check({faultPin_n, 3'h0, outputFloat}, 8'h0F);
         rd_chk(REG_SUPPLY, {4'h0, sup});
         sup = '0;
         recover();
      end
      powerOnReset = 1'b1;
      wait_cyc(5);
      check({7'h0, serialRelease}, 8'h01);
      powerOnReset = 1'b0;
      wait_cyc(5);
      check({7'h0, serialRelease}, 8'h00);
      ctl.reinit(g);
      recover();
      stop_test();
   end
endmodule
